// ==== logic/bgdd_gate_ctrl.v ====
// What this block does
// - Decoded high: low side off, zero-cross cleared, high after delay.
// - Decoded low: high side off, zero-cross cleared, low after delay.
// - Entering middle: high side off at once, low side after delay.
// - Middle: low side held high through blanking, zero-cross ignored.
// - After blanking, zero-cross detected drops the low side.
// - Middle with positive current: low side high, high side low.
// - Middle after zero current: both low until level changes.
// - Both gates low until supply passes start threshold, unless an overvoltage fault holds the low side high.
// - Above start threshold the decoded level governs the gates.
// - Supply under lower trip forces gates low until restart.
// - Early power-up switch-node overvoltage forces low side high.
// - Overvoltage fault latched, enable pulled low, cleared by reset.
// - Decoding only runs with supply armed and enable high.
// - Reset or lockout fault pulls the shared enable line low.
// - On rise wait for low side seen off, then delay, then high side.
// - Every change to low starts a timeout that forces the low side on.
`timescale 1ns/1ps
`default_nettype none
`include "bgdd_defines.vh"

module bgdd_gate_ctrl #(
    parameter TW = 16,
    parameter NOV_CYC = `BGDD_NOV_CYC,
    parameter BLANK_CYC = `BGDD_ZCD_BLANK_CYC,
    parameter LS_TO_CYC = `BGDD_LS_TO_CYC
) (
    input wire clock,
    input wire rst,
    input wire [1:0] pwm_code,
    input wire enable_in,
    output reg enable_out_reg,
    output reg enable_oe_reg,
    input wire supply_por_ok,
    input wire supply_start_ok,
    input wire supply_lockout,
    input wire switch_node_ov,
    input wire switch_node_low,
    input wire low_side_off_sense,
    input wire zero_cross_detect,
    output reg high_side_gate_cmd,
    output reg low_side_gate_cmd,
    output reg irq_reg,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam [3:0] ST_OFF = 4'h0;
localparam [3:0] ST_HI_WAIT = 4'h1;
localparam [3:0] ST_HI_DLY = 4'h2;
localparam [3:0] ST_HI_ON = 4'h3;
localparam [3:0] ST_LO_DLY = 4'h4;
localparam [3:0] ST_LO_ON = 4'h5;
localparam [3:0] ST_MID_DLY = 4'h6;
localparam [3:0] ST_MID_BLANK = 4'h7;
localparam [3:0] ST_MID_WATCH = 4'h8;
localparam [3:0] ST_MID_ZERO = 4'h9;

localparam [TW-1:0] NOV_LOAD = NOV_CYC[TW-1:0];
localparam [TW-1:0] BLANK_LOAD = BLANK_CYC[TW-1:0];
localparam [TW-1:0] TO_LOAD = LS_TO_CYC[TW-1:0];

// Unused code 2'b10 falls through to middle
function [1:0] decode_level;
    input [1:0] code;
    begin
        case (code)
            2'b00: decode_level = `BGDD_LVL_LOW;
            2'b11: decode_level = `BGDD_LVL_HIGH;
            default: decode_level = `BGDD_LVL_MID;
        endcase
    end
endfunction

// Entry state for a freshly seen level
function [3:0] entry_state;
    input [1:0] lvl;
    begin
        case (lvl)
            `BGDD_LVL_HIGH: entry_state = ST_HI_WAIT;
            `BGDD_LVL_LOW: entry_state = ST_LO_DLY;
            default: entry_state = ST_MID_DLY;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// Registers and wires
// ----------------------------------------------------------------------
reg [3:0] state_reg;
reg [3:0] state_next;
reg [1:0] lvl_reg;
reg drv_en_reg;
reg [`BGDD_IRQ_W-1:0] irq_stat_reg;
reg [`BGDD_IRQ_W-1:0] irq_mask_reg;
reg [`BGDD_IRQ_W-1:0] irq_set;
reg hs_next;
reg ls_next;
reg nov_load;
reg blank_load;
reg to_load;
reg zero_event;
reg to_event;
wire [1:0] lvl;
wire lvl_change;
wire run;
wire armed;
wire ov_fault;
wire lockout_event;
wire ov_event;
wire dly_busy;
wire to_busy;
wire [TW-1:0] dly_count;
wire apb_access;
wire apb_wr;
wire ofs_ok;

assign lvl = decode_level(pwm_code);
assign lvl_change = (lvl != lvl_reg);
assign run = armed & enable_in & drv_en_reg & ~ov_fault;
assign dly_count = blank_load ? BLANK_LOAD : NOV_LOAD;

// ----------------------------------------------------------------------
// Supply supervision and timers
// ----------------------------------------------------------------------
bgdd_supply_mon u_supply (
    .clock(clock),
    .rst(rst),
    .supply_por_ok(supply_por_ok),
    .supply_start_ok(supply_start_ok),
    .supply_lockout(supply_lockout),
    .switch_node_ov(switch_node_ov),
    .armed_reg(armed),
    .ov_fault_reg(ov_fault),
    .lockout_event(lockout_event),
    .ov_event(ov_event)
);

// One timer serves both non-overlap and blanking; they never overlap
bgdd_timer #(
    .W(TW)
) u_dly (
    .clock(clock),
    .rst(rst),
    .load(nov_load | blank_load),
    .count(dly_count),
    .busy(dly_busy)
);

bgdd_timer #(
    .W(TW)
) u_to (
    .clock(clock),
    .rst(rst),
    .load(to_load),
    .count(TO_LOAD),
    .busy(to_busy)
);

// ----------------------------------------------------------------------
// Gate sequencer
// ----------------------------------------------------------------------
always @* begin
    state_next = state_reg;
    nov_load = 1'b0;
    blank_load = 1'b0;
    to_load = 1'b0;
    zero_event = 1'b0;
    to_event = 1'b0;
    if (~run) begin
        state_next = ST_OFF;
    end else if (state_reg == ST_OFF || lvl_change) begin
        // Any level change restarts the sequence from its entry
        state_next = entry_state(lvl);
        if (lvl == `BGDD_LVL_LOW) begin
            nov_load = 1'b1;
            to_load = 1'b1;
        end else if (lvl != `BGDD_LVL_HIGH) begin
            nov_load = 1'b1;
        end
    end else begin
        case (state_reg)
            ST_HI_WAIT: begin
                if (low_side_off_sense) begin
                    state_next = ST_HI_DLY;
                    nov_load = 1'b1;
                end
            end
            ST_HI_DLY: begin
                if (~dly_busy) begin
                    state_next = ST_HI_ON;
                end
            end
            ST_LO_DLY: begin
                if (~dly_busy && switch_node_low) begin
                    state_next = ST_LO_ON;
                end else if (~to_busy) begin
                    // Forces a crowbar if the high side is shorted
                    state_next = ST_LO_ON;
                    to_event = 1'b1;
                end
            end
            ST_MID_DLY: begin
                if (~dly_busy) begin
                    state_next = ST_MID_BLANK;
                    blank_load = 1'b1;
                end
            end
            ST_MID_BLANK: begin
                if (~dly_busy) begin
                    state_next = ST_MID_WATCH;
                end
            end
            ST_MID_WATCH: begin
                if (zero_cross_detect) begin
                    state_next = ST_MID_ZERO;
                    zero_event = 1'b1;
                end
            end
            default: begin
                state_next = state_reg;
            end
        endcase
    end
end

// Gate levels follow the next state so outputs come from flip-flops
always @* begin
    hs_next = 1'b0;
    ls_next = 1'b0;
    case (state_next)
        ST_HI_ON: hs_next = 1'b1;
        ST_LO_ON: ls_next = 1'b1;
        ST_MID_BLANK: ls_next = 1'b1;
        ST_MID_WATCH: ls_next = 1'b1;
        ST_MID_ZERO: ls_next = 1'b0;
        default: ls_next = 1'b0;
    endcase
    if (ov_fault) begin
        hs_next = 1'b0;
        ls_next = 1'b1;
    end else if (~armed) begin
        hs_next = 1'b0;
        ls_next = 1'b0;
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        state_reg <= ST_OFF;
        lvl_reg <= `BGDD_LVL_MID;
        high_side_gate_cmd <= 1'b0;
        low_side_gate_cmd <= 1'b0;
        enable_out_reg <= 1'b0;
        enable_oe_reg <= 1'b1;
    end else begin
        state_reg <= state_next;
        lvl_reg <= lvl;
        high_side_gate_cmd <= hs_next;
        low_side_gate_cmd <= ls_next;
        enable_out_reg <= 1'b0;
        // Pulled low while not armed (before start or after lockout) or on latched fault, released otherwise
        enable_oe_reg <= ~armed | ov_fault;
    end
end

// ----------------------------------------------------------------------
// Register access
// ----------------------------------------------------------------------
assign apb_access = psel & penable & pready;
assign apb_wr = apb_access & pwrite & ~pslverr;
assign ofs_ok = (paddr == `BGDD_OFS_CTRL) ||
                (paddr == `BGDD_OFS_STAT) ||
                (paddr == `BGDD_OFS_IRQ_STAT) ||
                (paddr == `BGDD_OFS_IRQ_MASK);

always @* begin
    irq_set = {`BGDD_IRQ_W{1'b0}};
    irq_set[`BGDD_IRQ_OV] = ov_event;
    irq_set[`BGDD_IRQ_LOCKOUT] = lockout_event;
    irq_set[`BGDD_IRQ_ZERO] = zero_event;
    irq_set[`BGDD_IRQ_TIMEOUT] = to_event;
end

// Answer is registered in setup, so every access has no wait state
always @(posedge clock or posedge rst) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & ~ofs_ok;
        prdata <= 32'h00000000;
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `BGDD_OFS_CTRL: prdata <= {31'h0, drv_en_reg};
                `BGDD_OFS_STAT: prdata <= {20'h00000, state_reg,
                    lvl_reg, enable_in, run, ov_fault, armed,
                    low_side_gate_cmd, high_side_gate_cmd};
                `BGDD_OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat_reg};
                `BGDD_OFS_IRQ_MASK: prdata <= {28'h0000000, irq_mask_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        drv_en_reg <= 1'b1;
        irq_mask_reg <= `BGDD_MASK_RESET;
        irq_stat_reg <= {`BGDD_IRQ_W{1'b0}};
        irq_reg <= 1'b0;
    end else begin
        if (apb_wr && paddr == `BGDD_OFS_CTRL) begin
            drv_en_reg <= pwdata[`BGDD_CTRL_DRV_EN];
        end
        if (apb_wr && paddr == `BGDD_OFS_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`BGDD_IRQ_W-1:0];
        end
        // Write-one-to-clear; a new event in the same cycle survives
        if (apb_wr && paddr == `BGDD_OFS_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[`BGDD_IRQ_W-1:0]) |
                            irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
        irq_reg <= |((irq_stat_reg | irq_set) & irq_mask_reg);
    end
end

endmodule
`default_nettype wire

// ==== pkg/bgdd_defines.vh ====
`ifndef BGDD_DEFINES_VH
`define BGDD_DEFINES_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define BGDD_CLK_NS 50
`define BGDD_ZCD_BLANK_NS 250
// Least time, so round up
`define BGDD_ZCD_BLANK_CYC \
    ((`BGDD_ZCD_BLANK_NS + `BGDD_CLK_NS - 1) / `BGDD_CLK_NS)
`define BGDD_NOV_CYC 2
`define BGDD_LS_TO_CYC 40

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BGDD_OFS_CTRL 8'h00
`define BGDD_OFS_STAT 8'h04
`define BGDD_OFS_IRQ_STAT 8'h08
`define BGDD_OFS_IRQ_MASK 8'h0c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BGDD_CTRL_DRV_EN 0
`define BGDD_CTRL_RESET 32'h00000001
`define BGDD_IRQ_OV 0
`define BGDD_IRQ_LOCKOUT 1
`define BGDD_IRQ_ZERO 2
`define BGDD_IRQ_TIMEOUT 3
`define BGDD_IRQ_W 4
`define BGDD_MASK_RESET 4'h0

// ----------------------------------------------------------------------
// Decoded modulation levels
// ----------------------------------------------------------------------
`define BGDD_LVL_LOW 2'h0
`define BGDD_LVL_MID 2'h1
`define BGDD_LVL_HIGH 2'h3

`endif

// ==== logic/bgdd_timer.v ====
`timescale 1ns/1ps
`default_nettype none

module bgdd_timer #(
    parameter W = 16
) (
    input wire clock,
    input wire rst,
    input wire load,
    input wire [W-1:0] count,
    output wire busy
);

reg [W-1:0] cnt_reg;

// Reload wins over counting so every transition restarts the interval
always @(posedge clock or posedge rst) begin
    if (rst) begin
        cnt_reg <= {W{1'b0}};
    end else if (load) begin
        cnt_reg <= count;
    end else if (cnt_reg != {W{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
end

assign busy = (cnt_reg != {W{1'b0}});

endmodule
`default_nettype wire

// ==== logic/bgdd_supply_mon.v ====
`timescale 1ns/1ps
`default_nettype none

module bgdd_supply_mon (
    input wire clock,
    input wire rst,
    input wire supply_por_ok,
    input wire supply_start_ok,
    input wire supply_lockout,
    input wire switch_node_ov,
    output reg armed_reg,
    output reg ov_fault_reg,
    output wire lockout_event,
    output wire ov_event
);

reg started_reg;
wire ov_set;

// Overvoltage check only in the window between reset level and first start
assign ov_set = supply_por_ok & ~started_reg & switch_node_ov;
assign ov_event = ov_set & ~ov_fault_reg;
assign lockout_event = armed_reg & (supply_lockout | ~supply_por_ok);

always @(posedge clock or posedge rst) begin
    if (rst) begin
        armed_reg <= 1'b0;
        started_reg <= 1'b0;
        ov_fault_reg <= 1'b0;
    end else begin
        // Hysteresis: arm above start, disarm at the lower trip or under the reset level
        if (supply_lockout | ~supply_por_ok) begin
            armed_reg <= 1'b0;
        end else if (supply_start_ok) begin
            armed_reg <= 1'b1;
        end
        if (~supply_por_ok) begin
            started_reg <= 1'b0;
        end else if (supply_start_ok) begin
            started_reg <= 1'b1;
        end
        // Latched until the supply drops under the reset level
        if (~supply_por_ok) begin
            ov_fault_reg <= 1'b0;
        end else if (ov_set) begin
            ov_fault_reg <= 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ==== tb/bgdd_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Modulation controller on the far side
// ----------------------------------------
module bgdd_ctrl_model (
    input wire logic [1:0] level,
    input wire logic pull_low,
    input wire logic enable_oe_reg,
    input wire logic enable_out_reg,
    output logic [1:0] pwm_code,
    output logic enable_in,
    output logic shut
);
    assign pwm_code = level;
    // Shared line has a pull-up, so a released line reads high
    assign enable_in = !(pull_low || (enable_oe_reg && !enable_out_reg));
    assign shut = !enable_in;
endmodule
`default_nettype wire

// ==== tb/bgdd_gate_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bgdd_defines.vh"
module bgdd_gate_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] pwm_code,
    input wire logic enable_in,
    input wire logic enable_out_reg,
    input wire logic enable_oe_reg,
    input wire logic supply_por_ok,
    input wire logic supply_start_ok,
    input wire logic supply_lockout,
    input wire logic switch_node_ov,
    input wire logic low_side_off_sense,
    input wire logic zero_cross_detect,
    input wire logic high_side_gate_cmd,
    input wire logic low_side_gate_cmd,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready
);
    logic [4:0] mid_cnt;
    logic seen_start;
    // First start reached; early overvoltage is only watched before it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seen_start <= 1'b0;
        end else if (!supply_por_ok) begin
            seen_start <= 1'b0;
        end else if (supply_start_ok) begin
            seen_start <= 1'b1;
        end
    end
    // Run as seen at the pins; drive enable is kept set by the bench
    wire logic run = enable_in && !enable_oe_reg;
    wire logic mid = (^pwm_code) && run;
    wire logic hs = high_side_gate_cmd;
    wire logic ls = low_side_gate_cmd;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mid_cnt <= 5'h00;
        end else if (!mid) begin
            mid_cnt <= 5'h00;
        end else if (mid_cnt != 5'h1f) begin
            mid_cnt <= mid_cnt + 5'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_mid_rise;
        $rose(ls) && mid && $past(mid);
    endsequence
    // Twelve cycles in mid is past delay plus blanking in any reading
    sequence s_mid_late;
        mid && mid_cnt >= 5'h0c;
    endsequence
    a_no_overlap: assert property (!(hs && ls))
        else $error("both gates on");
    a_hs_drop: assert property (pwm_code != `BGDD_LVL_HIGH |=> !hs)
        else $error("high gate not dropped");
    a_hs_delay: assert property ($rose(hs) |->
        $past(pwm_code, 3) == `BGDD_LVL_HIGH && $past(low_side_off_sense))
        else $error("high gate early");
    a_hs_rise: assert property (
        (pwm_code == `BGDD_LVL_HIGH && low_side_off_sense && run)[*8] |-> hs)
        else $error("high gate missing");
    a_blank_hold: assert property (s_mid_rise ##1 mid[*2] |->
        ls && $past(ls))
        else $error("low gate cut in blanking");
    a_zc_drop: assert property (
        s_mid_late and ls && zero_cross_detect |=> !ls)
        else $error("zero cross ignored");
    a_zero_off: assert property (s_mid_late ##0 !ls ##1 mid |->
        !ls && !hs)
        else $error("gate after zero current");
    a_idle_low: assert property ((!enable_in)[*2] |=>
        !hs && (enable_oe_reg || !ls))
        else $error("gate while disabled");
    a_ov_force: assert property (supply_por_ok && !seen_start &&
        switch_node_ov && enable_oe_reg |-> ##[1:3]
        (ls && !hs && enable_oe_reg))
        else $error("overvoltage not handled");
    a_fault_pull: assert property (
        supply_lockout || !supply_por_ok |-> ##[1:2]
        (enable_oe_reg && !enable_out_reg))
        else $error("enable line not pulled");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
endmodule
bind bgdd_gate_ctrl bgdd_gate_monitor bgdd_gate_monitor_inst (
    .clock(clock), .rst(rst), .pwm_code(pwm_code), .enable_in(enable_in),
    .enable_out_reg(enable_out_reg), .enable_oe_reg(enable_oe_reg),
    .supply_por_ok(supply_por_ok), .supply_start_ok(supply_start_ok),
    .supply_lockout(supply_lockout), .switch_node_ov(switch_node_ov),
    .low_side_off_sense(low_side_off_sense),
    .zero_cross_detect(zero_cross_detect),
    .high_side_gate_cmd(high_side_gate_cmd),
    .low_side_gate_cmd(low_side_gate_cmd),
    .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire

// ==== tb/test_buck_gate_drive_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bgdd_defines.vh"
module test_buck_gate_drive_decoder;
    logic clock = 0, rst = 1, pull_low = 0, por = 0, start = 0, lock = 0;
    logic ov = 0, swlow = 0, lsoff = 0, zc = 0, pe;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [1:0] level = `BGDD_LVL_LOW;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdv;
    wire [1:0] pwm;
    wire [31:0] prdata;
    wire en, eoe, eout, hs, ls, irq, pready, pslverr, shut;
    int err_total = 0, num_checks = 0;
    always #25 clock = ~clock;
    bgdd_ctrl_model bgdd_ctrl_model_inst (.level(level), .pull_low(pull_low),
        .enable_oe_reg(eoe), .enable_out_reg(eout), .pwm_code(pwm),
        .enable_in(en), .shut(shut));
    bgdd_gate_ctrl bgdd_gate_ctrl_inst (.clock(clock), .rst(rst),
        .pwm_code(pwm), .enable_in(en), .enable_out_reg(eout),
        .enable_oe_reg(eoe), .supply_por_ok(por), .supply_start_ok(start),
        .supply_lockout(lock), .switch_node_ov(ov), .switch_node_low(swlow),
        .low_side_off_sense(lsoff), .zero_cross_detect(zc),
        .high_side_gate_cmd(hs), .low_side_gate_cmd(ls), .irq_reg(irq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("unexpected at %0t: bus answer timed out", $time);
            final_report;
        end
        rdv = prdata;
        pe = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, 32'h0);
        chk(rdv, x);
    endtask
    // Waits for a gate to reach v; edges counted must fall in lo..hi
    task wt(input logic s, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while ((s ? ls : hs) !== v && n <= hi) begin
            @(posedge clock);
            n++;
        end
        if (n > hi) begin
            err_total++;
            $display("unexpected at %0t: gate wait timed out", $time);
            final_report;
        end
        chk(n >= lo, 1);
    endtask
    initial begin
        cyc(2);
        rst <= 0;
        chk({eoe, eout, hs, ls}, 4'b1000);
        rd(`BGDD_OFS_CTRL, `BGDD_CTRL_RESET);
        rd(`BGDD_OFS_IRQ_MASK, 32'h0);
        apb(1, 8'h10, 32'h1);
        chk(pe, 1);
        por <= 1;
        ov <= 1;
        cyc(4);
        chk({eoe, en, hs, ls}, 4'b1001);
        rd(`BGDD_OFS_IRQ_STAT, 32'h1);
        apb(1, `BGDD_OFS_IRQ_MASK, 32'hf);
        cyc(2);
        chk(irq, 1);
        ov <= 0;
        start <= 1;
        cyc(4);
        chk({eoe, ls}, 2'b11);
        apb(1, `BGDD_OFS_IRQ_STAT, 32'hf);
        rd(`BGDD_OFS_IRQ_STAT, 32'h0);
        chk(irq, 0);
        por <= 0;
        cyc(2);
        por <= 1;
        cyc(4);
        chk({eoe, en}, 2'b01);
        $display("power-up test done");
        swlow <= 1;
        wt(1, 1, `BGDD_NOV_CYC, 44);
        level <= `BGDD_LVL_HIGH;
        swlow <= 0;
        wt(1, 0, 1, 2);
        cyc(8);
        chk(hs, 0);
        lsoff <= 1;
        wt(0, 1, 3, 6);
        level <= `BGDD_LVL_LOW;
        lsoff <= 0;
        wt(0, 0, 1, 2);
        wt(1, 1, 36, 44);
        // Power cycle above also logged a lockout entry
        rd(`BGDD_OFS_IRQ_STAT, 32'ha);
        apb(1, `BGDD_OFS_IRQ_STAT, 32'hf);
        $display("high and low test done");
        level <= `BGDD_LVL_HIGH;
        lsoff <= 1;
        wt(0, 1, 3, 8);
        level <= 2'h2;
        zc <= 1;
        wt(0, 0, 1, 2);
        wt(1, 1, 2, 4);
        cyc(3);
        chk(ls, 1);
        wt(1, 0, 1, 6);
        cyc(10);
        chk({hs, ls}, 2'b00);
        rd(`BGDD_OFS_IRQ_STAT, 32'h4);
        apb(1, `BGDD_OFS_IRQ_STAT, 32'hf);
        level <= `BGDD_LVL_HIGH;
        zc <= 0;
        wt(0, 1, 3, 8);
        level <= `BGDD_LVL_MID;
        wt(1, 1, 3, 6);
        cyc(20);
        chk({hs, ls}, 2'b01);
        zc <= 1;
        wt(1, 0, 1, 3);
        $display("mid level test done");
        level <= `BGDD_LVL_HIGH;
        pull_low <= 1;
        cyc(12);
        chk({shut, hs, ls}, 3'b100);
        pull_low <= 0;
        wt(0, 1, 3, 10);
        lock <= 1;
        start <= 0;
        cyc(3);
        chk({eoe, en, hs, ls, shut}, 5'b10001);
        lock <= 0;
        start <= 1;
        wt(0, 1, 3, 12);
        rd(`BGDD_OFS_STAT, 32'h3f5);
        rd(`BGDD_OFS_IRQ_STAT, 32'h6);
        chk(irq, 1);
        apb(1, `BGDD_OFS_IRQ_MASK, 32'h0);
        cyc(2);
        chk(irq, 0);
        $display("enable and lockout test done");
        final_report;
    end
endmodule
`default_nettype wire
